// file: citsel_pkg.sv
// Constants and message object store for the interface transfer select block
// Summary of operation
// - A write transfer with the identifier select set copies id, frame kind, extended flag and object_valid into the object.
// - A read transfer with the identifier select set loads those arbitration values from the object into the buffer.
// - A write transfer with the control select (bit 4) set copies the control fields into the object.
// - A read transfer with the control select set loads the object's control fields into the buffer.
// - The clear_pending_select bit (bit 3) has no effect on a write transfer.
// - A read transfer with clear_pending_select set clears the object's pending_flag.
// - A write transfer with bit 2 set sets the object's transmit_request, ignoring the buffer's transmit_request value.
// - A read transfer with bit 2 set clears the object's fresh_data_flag.
// - A read that also clears flags returns their values from before the clear.
// - A write transfer with low_bytes_select (bit 1) set copies data bytes 0 to 3 into the object.
// - A read transfer with low_bytes_select set loads object bytes 0 to 3 into the two low data words.
// - A write transfer with high_bytes_select (bit 0) set copies data bytes 4 to 7 into the object.
// - A read transfer with high_bytes_select set loads object bytes 4 to 7 into the two high data words.
// - Writing an object_number while not busy starts the transfer and sets busy, which clears 4 clock periods later.
// - Object number 0x00 means object 32 and 0x21 to 0x3F wrap onto objects 1 to 31.

package citsel_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_CMD_REQUEST = 8'h00;
    localparam logic [7:0] OFF_XFER_SELECT = 8'h04;
    localparam logic [7:0] OFF_ARB         = 8'h08;
    localparam logic [7:0] OFF_MSG_CTRL    = 8'h0C;
    localparam logic [7:0] OFF_LOW_ONE     = 8'h10;
    localparam logic [7:0] OFF_LOW_TWO     = 8'h14;
    localparam logic [7:0] OFF_HIGH_ONE    = 8'h18;
    localparam logic [7:0] OFF_HIGH_TWO    = 8'h1C;

    // ****************************************
    // Field positions and widths
    // ****************************************
    localparam int BUSY_BIT     = 15;
    localparam int OBJ_NUM_W    = 6;
    localparam int OBJ_IDX_W    = 5;
    localparam int SEL_W        = 6;
    localparam int DIR_BIT      = 7;
    localparam int SEL_ARB      = 5;
    localparam int SEL_CTRL     = 4;
    localparam int SEL_CLR_PEND = 3;
    localparam int SEL_TXRQ_NEW = 2;
    localparam int SEL_LOW      = 1;
    localparam int SEL_HIGH     = 0;
    localparam int CTRL_W       = 16;
    localparam int FRESH_BIT    = 15;
    localparam int PEND_BIT     = 13;
    localparam int TXRQ_BIT     = 8;
    localparam int HALF_W       = 16;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [5:0]  OBJ_NUM_RESET = 6'h01;
    localparam logic [7:0]  SELECT_RESET  = 8'h00;
    localparam logic [31:0] ARB_RESET     = 32'h0000_0000;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] DATA_RESET    = 16'h0000;
    localparam int XFER_PERIODS = 4;
    localparam int XFER_CYCLES  = (XFER_PERIODS < 1) ? 1 : XFER_PERIODS;

    typedef enum logic [1:0] {
        CITSEL_IDLE = 2'b01,
        CITSEL_RUN  = 2'b10
    } citsel_state_t;
endpackage

// Message object store, one entry per object, flip-flops indexed by number
module citsel_obj_store #(
    parameter int OBJECTS = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [4:0]  idx,
    input  wire logic        wr_arb,
    input  wire logic        wr_ctrl,
    input  wire logic        set_txrq,
    input  wire logic        clr_pend,
    input  wire logic        clr_fresh,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [31:0] arb_in,
    input  wire logic [15:0] ctrl_in,
    input  wire logic [31:0] low_in,
    input  wire logic [31:0] high_in,
    output logic      [31:0] arb_out,
    output logic      [15:0] ctrl_out,
    output logic      [31:0] low_out,
    output logic      [31:0] high_out
);
    logic [31:0] arb_mem  [OBJECTS];
    logic [15:0] ctrl_mem [OBJECTS];
    logic [31:0] low_mem  [OBJECTS];
    logic [31:0] high_mem [OBJECTS];

    assign arb_out  = arb_mem[idx];
    assign ctrl_out = ctrl_mem[idx];
    assign low_out  = low_mem[idx];
    assign high_out = high_mem[idx];

    for (genvar g = 0; g < OBJECTS; g++) begin : g_obj
        localparam int OBJ_IDX = citsel_pkg::OBJ_IDX_W;
        logic hit;
        assign hit = (idx == OBJ_IDX'(g));

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                arb_mem[g]  <= citsel_pkg::ARB_RESET;
                low_mem[g]  <= {2{citsel_pkg::DATA_RESET}};
                high_mem[g] <= {2{citsel_pkg::DATA_RESET}};
            end else if (hit) begin
                if (wr_arb) begin
                    arb_mem[g] <= arb_in;
                end
                if (wr_low) begin
                    low_mem[g] <= low_in;
                end
                if (wr_high) begin
                    high_mem[g] <= high_in;
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl_mem[g] <= citsel_pkg::CTRL_RESET;
            end else if (hit) begin
                if (wr_ctrl) begin
                    ctrl_mem[g] <= ctrl_in;
                end
                if (set_txrq) begin
                    ctrl_mem[g][citsel_pkg::TXRQ_BIT] <= 1'b1;
                end
                if (clr_pend) begin
                    ctrl_mem[g][citsel_pkg::PEND_BIT] <= 1'b0;
                end
                if (clr_fresh) begin
                    ctrl_mem[g][citsel_pkg::FRESH_BIT] <= 1'b0;
                end
            end
        end
    end
endmodule

// file: citsel_props.sv
// Port-level assertion checker for the transfer select block
module citsel_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       acc;
    logic       cmd_wr;
    logic       cmd_rd;
    logic [5:0] num_seen;
    logic [7:0] sel_seen;

    assign acc    = psel && penable;
    assign cmd_wr = acc && pwrite && paddr == 8'h00;
    assign cmd_rd = acc && !pwrite && paddr == 8'h00;

    // Starts taken while busy are dropped, so the shadow skips them too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            num_seen <= 6'h01;
        end else if (cmd_wr && !busy) begin
            num_seen <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_seen <= 8'h00;
        end else if (acc && pwrite && paddr == 8'h04) begin
            sel_seen <= pwdata[7:0] & 8'hBF;
        end
    end

    busy_start_a: assert property (cmd_wr && !busy |=> busy)
        else $error("busy did not rise after a start");
    busy_len_a: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
        else $error("busy length is not four cycles");
    busy_cause_a: assert property ($rose(busy) |-> $past(cmd_wr))
        else $error("busy rose without a start");
    busy_idle_a: assert property (!busy && !cmd_wr |=> !busy)
        else $error("busy rose on its own");
    busy_view_a: assert property (cmd_rd |-> prdata[15] == busy)
        else $error("busy bit readback wrong");
    cmd_resv_a: assert property (cmd_rd |-> prdata[31:16] == 16'h0000 && prdata[14:6] == 9'h000)
        else $error("command reserved bits not zero");
    num_view_a: assert property (cmd_rd |-> prdata[5:0] == num_seen)
        else $error("object number readback wrong");
    sel_view_a: assert property (acc && !pwrite && paddr == 8'h04 |-> prdata[7:0] == sel_seen)
        else $error("transfer select readback wrong");
    ready_high_a: assert property (acc |-> pready)
        else $error("pready low in an access cycle");
    err_map_a: assert property (acc |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'b00))
        else $error("pslverr does not match the address map");
endmodule

bind citsel_top citsel_props u_props (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .busy(busy)
);

// file: citsel_top.sv
// Interface buffer registers, transfer select and command engine on APB
module citsel_top #(
    parameter int OBJECTS = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy
);
    // ****************************************
    // Registers and state
    // ****************************************
    logic [citsel_pkg::OBJ_NUM_W-1:0] object_number;
    logic [7:0]                       transfer_select;
    logic [31:0]                      arb_buf;
    logic [15:0]                      message_control_buffer;
    logic [15:0]                      low_data_word_one;
    logic [15:0]                      low_data_word_two;
    logic [15:0]                      high_data_word_one;
    logic [15:0]                      high_data_word_two;
    citsel_pkg::citsel_state_t        state;
    citsel_pkg::citsel_state_t        next_state;
    logic [2:0]                       cycle_cnt;
    logic [citsel_pkg::OBJ_IDX_W-1:0] run_idx;
    logic [7:0]                       run_select;
    logic                             wr_access;
    logic                             start;
    logic                             exchange;
    logic                             dir_write;
    logic                             dir_read;
    logic                             mapped;
    logic [15:0]                      ctrl_to_obj;
    logic [31:0]                      obj_arb;
    logic [15:0]                      obj_ctrl;
    logic [31:0]                      obj_low;
    logic [31:0]                      obj_high;

    localparam logic [2:0] LAST_CYCLE = 3'(citsel_pkg::XFER_CYCLES - 1);

    // ****************************************
    // APB slave
    // ****************************************
    // Zero wait states: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign wr_access = psel && penable && pwrite;

    always_comb begin
        mapped = 1'b1;
        prdata = 32'h0000_0000;
        unique case (paddr)
            citsel_pkg::OFF_CMD_REQUEST: begin
                prdata[citsel_pkg::BUSY_BIT]              = busy;
                prdata[citsel_pkg::OBJ_NUM_W-1:0]         = object_number;
            end
            citsel_pkg::OFF_XFER_SELECT: prdata[7:0]      = transfer_select;
            citsel_pkg::OFF_ARB:         prdata           = arb_buf;
            citsel_pkg::OFF_MSG_CTRL:    prdata[15:0]     = message_control_buffer;
            citsel_pkg::OFF_LOW_ONE:     prdata[15:0]     = low_data_word_one;
            citsel_pkg::OFF_LOW_TWO:     prdata[15:0]     = low_data_word_two;
            citsel_pkg::OFF_HIGH_ONE:    prdata[15:0]     = high_data_word_one;
            citsel_pkg::OFF_HIGH_TWO:    prdata[15:0]     = high_data_word_two;
            default:                     mapped           = 1'b0;
        endcase
    end

    // Unmapped addresses answer with an error, writes to them are dropped
    assign pslverr = psel && penable && !mapped;

    // ****************************************
    // Command request and select registers
    // ****************************************
    // A start while busy is dropped so a running exchange keeps its target
    assign start = wr_access && (paddr == citsel_pkg::OFF_CMD_REQUEST) && !busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            object_number <= citsel_pkg::OBJ_NUM_RESET;
        end else if (start) begin
            object_number <= pwdata[citsel_pkg::OBJ_NUM_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_select <= citsel_pkg::SELECT_RESET;
        end else if (wr_access && paddr == citsel_pkg::OFF_XFER_SELECT) begin
            transfer_select <= {pwdata[citsel_pkg::DIR_BIT], 1'b0,
                                pwdata[citsel_pkg::SEL_W-1:0]};
        end
    end

    // ****************************************
    // Transfer engine
    // ****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            citsel_pkg::CITSEL_IDLE: if (start) next_state = citsel_pkg::CITSEL_RUN;
            citsel_pkg::CITSEL_RUN:  if (cycle_cnt == LAST_CYCLE) next_state = citsel_pkg::CITSEL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= citsel_pkg::CITSEL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign busy     = (state == citsel_pkg::CITSEL_RUN);
    assign exchange = busy && (cycle_cnt == LAST_CYCLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_cnt <= 3'h0;
        end else if (start || exchange) begin
            cycle_cnt <= 3'h0;
        end else if (busy) begin
            cycle_cnt <= cycle_cnt + 3'h1;
        end
    end

    // Number and select are frozen at start so late writes cannot tear a transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_idx    <= '0;
            run_select <= citsel_pkg::SELECT_RESET;
        end else if (start) begin
            // 0x00 wraps to 32, 0x21..0x3F wrap to 1..31
            run_idx    <= citsel_pkg::OBJ_IDX_W'(pwdata[citsel_pkg::OBJ_NUM_W-1:0]
                                                 - 6'h01);
            run_select <= transfer_select;
        end
    end

    assign dir_write = exchange && run_select[citsel_pkg::DIR_BIT];
    assign dir_read  = exchange && !run_select[citsel_pkg::DIR_BIT];

    // Buffer transmit request is ignored when bit 2 asks for one
    always_comb begin
        ctrl_to_obj = message_control_buffer;
        if (run_select[citsel_pkg::SEL_TXRQ_NEW]) begin
            ctrl_to_obj[citsel_pkg::TXRQ_BIT] = 1'b1;
        end
    end

    citsel_obj_store #(
        .OBJECTS (OBJECTS)
    ) u_store (
        .pclk      (pclk),
        .presetn   (presetn),
        .idx       (run_idx),
        .wr_arb    (dir_write && run_select[citsel_pkg::SEL_ARB]),
        .wr_ctrl   (dir_write && run_select[citsel_pkg::SEL_CTRL]),
        .set_txrq  (dir_write && run_select[citsel_pkg::SEL_TXRQ_NEW]),
        .clr_pend  (dir_read && run_select[citsel_pkg::SEL_CLR_PEND]),
        .clr_fresh (dir_read && run_select[citsel_pkg::SEL_TXRQ_NEW]),
        .wr_low    (dir_write && run_select[citsel_pkg::SEL_LOW]),
        .wr_high   (dir_write && run_select[citsel_pkg::SEL_HIGH]),
        .arb_in    (arb_buf),
        .ctrl_in   (ctrl_to_obj),
        .low_in    ({low_data_word_two, low_data_word_one}),
        .high_in   ({high_data_word_two, high_data_word_one}),
        .arb_out   (obj_arb),
        .ctrl_out  (obj_ctrl),
        .low_out   (obj_low),
        .high_out  (obj_high)
    );

    // ****************************************
    // Interface buffer registers
    // ****************************************
    // A read exchange wins over a software write landing on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arb_buf <= citsel_pkg::ARB_RESET;
        end else if (dir_read && run_select[citsel_pkg::SEL_ARB]) begin
            arb_buf <= obj_arb;
        end else if (wr_access && paddr == citsel_pkg::OFF_ARB) begin
            arb_buf <= pwdata;
        end
    end

    // Object flags are sampled on the clearing edge, so old values land here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            message_control_buffer <= citsel_pkg::CTRL_RESET;
        end else if (dir_read && run_select[citsel_pkg::SEL_CTRL]) begin
            message_control_buffer <= obj_ctrl;
        end else if (wr_access && paddr == citsel_pkg::OFF_MSG_CTRL) begin
            message_control_buffer <= pwdata[citsel_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_data_word_one <= citsel_pkg::DATA_RESET;
            low_data_word_two <= citsel_pkg::DATA_RESET;
        end else if (dir_read && run_select[citsel_pkg::SEL_LOW]) begin
            low_data_word_one <= obj_low[citsel_pkg::HALF_W-1:0];
            low_data_word_two <= obj_low[31:citsel_pkg::HALF_W];
        end else if (wr_access && paddr == citsel_pkg::OFF_LOW_ONE) begin
            low_data_word_one <= pwdata[citsel_pkg::HALF_W-1:0];
        end else if (wr_access && paddr == citsel_pkg::OFF_LOW_TWO) begin
            low_data_word_two <= pwdata[citsel_pkg::HALF_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_data_word_one <= citsel_pkg::DATA_RESET;
            high_data_word_two <= citsel_pkg::DATA_RESET;
        end else if (dir_read && run_select[citsel_pkg::SEL_HIGH]) begin
            high_data_word_one <= obj_high[citsel_pkg::HALF_W-1:0];
            high_data_word_two <= obj_high[31:citsel_pkg::HALF_W];
        end else if (wr_access && paddr == citsel_pkg::OFF_HIGH_ONE) begin
            high_data_word_one <= pwdata[citsel_pkg::HALF_W-1:0];
        end else if (wr_access && paddr == citsel_pkg::OFF_HIGH_TWO) begin
            high_data_word_two <= pwdata[citsel_pkg::HALF_W-1:0];
        end
    end
endmodule

// file: testbench.sv
// Self-checking APB bench for the transfer select block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [31:0] rd;
    logic        err_seen;
    int          errors;
    int          num_checks;
    int          cycles;

    citsel_top DUT (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .busy(busy)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Timeout
    // ****************************************
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One transfer, then an idle cycle so psel is never driven twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask

    // Word pattern per buffer register index
    function automatic logic [31:0] pat(input logic [15:0] v, input int i);
        return (i == 2) ? {v, ~v} : {16'h0000, v + 16'(i)};
    endfunction

    task automatic fill(input logic [15:0] v);
        for (int i = 2; i < 8; i++) apb(1'b1, 8'(i * 4), pat(v, i));
    endtask

    task automatic xfer(input logic [7:0] sel, input logic [7:0] num);
        int n;
        n = 0;
        apb(1'b1, 8'h04, {24'h000000, sel});
        apb(1'b1, 8'h00, {24'h000000, num});
        while (busy !== 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check("busy done", {31'h0, busy}, 32'h0);
    endtask

    task automatic bufs(input logic [15:0] va, input logic [31:0] ctl, input logic [15:0] vl,
                        input logic [15:0] vh);
        rchk(8'h08, pat(va, 2), "arb buf");
        rchk(8'h0C, ctl, "ctrl buf");
        for (int i = 4; i < 6; i++) rchk(8'(i * 4), pat(vl, i), "low buf");
        for (int i = 6; i < 8; i++) rchk(8'(i * 4), pat(vh, i), "high buf");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(8'h00, 32'h0000_0001, "cmd reset");
        for (int i = 1; i < 8; i++) rchk(8'(i * 4), 32'h0, "reg reset");
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped err", {31'h0, err_seen}, 32'h1);
        // Write all parts; clear-pending select must be ignored here
        fill(16'hA0F0);
        xfer(8'hBF, 8'h05);
        fill(16'h1234);
        // 0x25 wraps onto object 5
        xfer(8'h33, 8'h25);
        bufs(16'hA0F0, 32'h0000_A1F3, 16'hA0F0, 16'hA0F0);
        xfer(8'h14, 8'h05);
        bufs(16'hA0F0, 32'h0000_A1F3, 16'hA0F0, 16'hA0F0);
        xfer(8'h18, 8'h05);
        rchk(8'h0C, 32'h0000_21F3, "fresh cleared");
        xfer(8'h10, 8'h05);
        rchk(8'h0C, 32'h0000_01F3, "pend cleared");
        // Low half only reaches the object
        fill(16'h1234);
        xfer(8'h82, 8'h05);
        fill(16'h5555);
        xfer(8'h23, 8'h05);
        bufs(16'hA0F0, pat(16'h5555, 3), 16'h1234, 16'hA0F0);
        fill(16'h0F0F);
        xfer(8'hA3, 8'h00);
        fill(16'h7777);
        xfer(8'h23, 8'h20);
        bufs(16'h0F0F, pat(16'h7777, 3), 16'h0F0F, 16'h0F0F);
        // Bit 2 alone on a write must set the request in an object whose control was never written
        xfer(8'h84, 8'h20);
        xfer(8'h10, 8'h20);
        rchk(8'h0C, 32'h0000_0100, "txrq set");
        // Second start while busy is dropped
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h07);
        apb(1'b1, 8'h00, 32'h09);
        repeat (6) @(posedge pclk);
        rchk(8'h00, 32'h0000_0007, "num kept");
        end_sim();
    end
endmodule
